// *** mcd_pkg.sv ***
// Overview of operation
// - Command 00h identifies only after address 80h/90h
// - Command 73h returns one revision byte
// - Transfer read changes nothing, replies at most 14
// - 70h/71h write/read operating conditions
// - 46h/47h write/read chip configuration
// - 60h/61h write/read operating functions
// - 54h/55h write/read line I/O direction
// - 4Ah/4Bh write/read operating mode
// - 53h reads line I/O inputs
// - C8h/C9h write/read debounce time
// - E8h/E9h write/read ground-key sampling interval
// - 4Dh and 4Fh both read real-time data
// - 6Ch/6Dh write/read interrupt mask
// - 50h/51h write/read impedance scaling, analog gains
// - 80h/81h write/read transmit gain filter
// - 82h/83h write/read receive gain filter
// - 98h/99h write/read impedance FIR coefficients
// - 86h/87h write/read first balance FIR
// - 88h/89h, 8Ah/8Bh write/read equalizer sets
// - 96h/97h write/read second balance IIR
// - 9Ah/9Bh write/read impedance IIR coefficients
// - 00h puts addressed channel in standby
// - 02h resets addressed channel, keeps sampling interval
// - 04h resets every channel
// - 0Eh activates; voice valid after second sync
package mcd_pkg;
  localparam logic [7:0] ADDR_MASK = 8'he6;
  localparam logic [7:0] ADDR_MATCH = 8'h80;
  localparam int ADDR_CHAN_BIT = 4;
  localparam int ADDR_BOTH_BIT = 3;
  localparam int ADDR_CMD_BIT = 0;
  localparam logic [7:0] CMD_IDENT = 8'h00;
  localparam logic [7:0] CMD_DEACT = 8'h00;
  localparam logic [7:0] CMD_SOFT_RST = 8'h02;
  localparam logic [7:0] CMD_HARD_RST = 8'h04;
  localparam logic [7:0] CMD_ACTIVATE = 8'h0e;
  localparam logic [7:0] CMD_REVISION = 8'h73;
  localparam logic [7:0] CMD_LINE_IO = 8'h53;
  localparam logic [7:0] CMD_RT_A = 8'h4d;
  localparam logic [7:0] CMD_RT_B = 8'h4f;
  localparam logic [7:0] IDENT_HEAD = 8'h80;
  localparam logic [7:0] IDENT_TYPE = 8'h86;
  localparam logic [3:0] IDENT_LEN = 4'h2;
  localparam logic [3:0] MAX_READ = 4'he;
  localparam logic [1:0] VOICE_FRAMES = 2'h2;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int NUM_TGT = 17;
  localparam int MEM_BYTES = 71;
  localparam logic [4:0] TGT_CHIP = 5'h01;
  localparam logic [4:0] TGT_GKI = 5'h06;
  // Write codes; read is code plus one
  localparam logic [7:0] TGT_CODE [NUM_TGT] = '{
    8'h70, 8'h46, 8'h60, 8'h54, 8'h4a, 8'hc8, 8'he8, 8'h6c, 8'h50,
    8'h80, 8'h82, 8'h98, 8'h86, 8'h88, 8'h8a, 8'h96, 8'h9a};
  localparam logic [3:0] TGT_LEN [NUM_TGT] = '{
    4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h2,
    4'h2, 4'h2, 4'ha, 4'he, 4'hc, 4'he, 4'h2, 4'h5};
  localparam logic [6:0] TGT_BASE [NUM_TGT] = '{
    7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08,
    7'h0a, 7'h0c, 7'h0e, 7'h18, 7'h26, 7'h32, 7'h40, 7'h42};
  typedef enum logic [3:0] {
    K_NONE, K_WRITE, K_READ, K_REV, K_LINE_IO, K_RT,
    K_DEACT, K_SRST, K_HRST, K_ACT, K_IDENT
  } kind_e;
  typedef enum logic [4:0] {
    ST_ADDR = 5'b00001,
    ST_CMD = 5'b00010,
    ST_WRITE = 5'b00100,
    ST_SEND = 5'b01000,
    ST_DRAIN = 5'b10000
  } state_e;
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } link_word_s;
  typedef struct packed {
    kind_e kind;
    logic [4:0] target;
  } cmd_s;
endpackage

// *** monitor_command_decoder.sv ***
`timescale 1ns/1ns
module monitor_command_decoder #(
  // Arbitrary value
  parameter logic [7:0] REVISION = 8'h21
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic linkClock,
  input wire logic dnStrobe,
  input wire logic [7:0] dnData,
  input wire logic dnEnd,
  input wire logic frameSync,
  input wire logic upTake,
  input wire logic [7:0] lineIoIn,
  input wire logic [7:0] realTimeIn,
  output logic [7:0] upByte,
  output logic upValid,
  output logic upLast,
  output logic [1:0] channelActive,
  output logic [1:0] voiceValid,
  output logic [1:0] chanResetPulse,
  output logic chipResetPulse,
  output logic [7:0] chipCfg
);

  //////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic mcd_pkg::cmd_s decodeCmd(input logic [7:0] cmd);
    mcd_pkg::cmd_s d;
    d.kind = mcd_pkg::K_NONE;
    d.target = 5'h00;
    for (int i = 0; i < mcd_pkg::NUM_TGT; i++) begin
      if (cmd[7:1] == mcd_pkg::TGT_CODE[i][7:1]) begin
        d.kind = cmd[0] ? mcd_pkg::K_READ : mcd_pkg::K_WRITE;
        d.target = 5'(i);
      end
    end
    if (cmd == mcd_pkg::CMD_REVISION) begin
      d.kind = mcd_pkg::K_REV;
    end
    if (cmd == mcd_pkg::CMD_LINE_IO) begin
      d.kind = mcd_pkg::K_LINE_IO;
    end
    if (cmd == mcd_pkg::CMD_RT_A || cmd == mcd_pkg::CMD_RT_B) begin
      d.kind = mcd_pkg::K_RT;
    end
    if (cmd == mcd_pkg::CMD_DEACT) begin
      d.kind = mcd_pkg::K_DEACT;
    end
    if (cmd == mcd_pkg::CMD_SOFT_RST) begin
      d.kind = mcd_pkg::K_SRST;
    end
    if (cmd == mcd_pkg::CMD_HARD_RST) begin
      d.kind = mcd_pkg::K_HRST;
    end
    if (cmd == mcd_pkg::CMD_ACTIVATE) begin
      d.kind = mcd_pkg::K_ACT;
    end
    return d;
  endfunction

  function automatic logic isGlobal(input logic [4:0] tgt);
    return tgt == mcd_pkg::TGT_CHIP || tgt == mcd_pkg::TGT_GKI;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Link domain

  logic linkRstMeta;
  logic linkRst;
  logic dnToggle;
  mcd_pkg::link_word_s dnHold;
  logic fscToggle;
  logic upReqMeta;
  logic upReqSync;
  logic upReqSeen;
  logic upAck;
  mcd_pkg::link_word_s upHold;
  logic upReq;

  always_ff @(posedge linkClock) begin
    linkRstMeta <= srst;
    linkRst <= linkRstMeta;
  end

  always_ff @(posedge linkClock) begin
    upReqMeta <= upReq;
    upReqSync <= upReqMeta;
  end

  // Each downstream byte or end of message becomes one toggle event
  always_ff @(posedge linkClock) begin
    if (linkRst) begin
      dnToggle <= 1'b0;
      dnHold <= '0;
    end else if (dnStrobe || dnEnd) begin
      dnHold.data <= dnData;
      dnHold.last <= dnEnd;
      dnToggle <= ~dnToggle;
    end
  end

  always_ff @(posedge linkClock) begin
    if (linkRst) begin
      fscToggle <= 1'b0;
    end else if (frameSync) begin
      fscToggle <= ~fscToggle;
    end
  end

  // Upstream byte stands until the link takes it
  always_ff @(posedge linkClock) begin
    if (linkRst) begin
      upReqSeen <= 1'b0;
      upByte <= 8'h00;
      upLast <= 1'b0;
      upValid <= 1'b0;
      upAck <= 1'b0;
    end else begin
      upReqSeen <= upReqSync;
      if (upReqSync != upReqSeen) begin
        upByte <= upHold.data;
        upLast <= upHold.last;
        upValid <= 1'b1;
      end else if (upValid && upTake) begin
        upValid <= 1'b0;
        upAck <= ~upAck;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Crossings into the core domain

  logic dnTogMeta;
  logic dnTogSync;
  logic dnTogSeen;
  logic fscMeta;
  logic fscSync;
  logic fscSeen;
  logic ackMeta;
  logic ackSync;
  logic [7:0] ioMeta;
  logic [7:0] ioSync;
  logic [7:0] rtMeta;
  logic [7:0] rtSync;

  always_ff @(posedge clock) begin
    dnTogMeta <= dnToggle;
    dnTogSync <= dnTogMeta;
    fscMeta <= fscToggle;
    fscSync <= fscMeta;
    ackMeta <= upAck;
    ackSync <= ackMeta;
    ioMeta <= lineIoIn;
    ioSync <= ioMeta;
    rtMeta <= realTimeIn;
    rtSync <= rtMeta;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      dnTogSeen <= 1'b0;
      fscSeen <= 1'b0;
    end else begin
      dnTogSeen <= dnTogSync;
      fscSeen <= fscSync;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Message decoding

  mcd_pkg::state_e state;
  mcd_pkg::state_e next_state;
  logic [7:0] addrByte;
  mcd_pkg::cmd_s cur;
  logic [3:0] idx;
  logic [1:0] softRst;
  logic hardRst;
  logic [7:0] mem [2][mcd_pkg::MEM_BYTES];

  wire wordIn = dnTogSync ^ dnTogSeen;
  wire isEom = wordIn & dnHold.last;
  wire isByte = wordIn & ~dnHold.last;
  wire fscEvent = fscSync ^ fscSeen;
  wire addrOk = (dnHold.data & mcd_pkg::ADDR_MASK) == mcd_pkg::ADDR_MATCH;
  wire mcd_pkg::cmd_s dec = decodeCmd(dnHold.data);
  wire normalAddr = addrByte[mcd_pkg::ADDR_CMD_BIT];
  wire identReq = !normalAddr && !addrByte[mcd_pkg::ADDR_BOTH_BIT]
    && dnHold.data == mcd_pkg::CMD_IDENT;
  wire cmdTake = isByte && state == mcd_pkg::ST_CMD && normalAddr;
  wire identTake = isByte && state == mcd_pkg::ST_CMD && identReq;
  wire chanSel = addrByte[mcd_pkg::ADDR_CHAN_BIT];
  wire [1:0] tgtMask = addrByte[mcd_pkg::ADDR_BOTH_BIT] ? 2'b11
    : (chanSel ? 2'b10 : 2'b01);
  wire [1:0] wrMask = isGlobal(cur.target) ? 2'b01 : tgtMask;
  wire [3:0] curLen = mcd_pkg::TGT_LEN[cur.target];
  wire [6:0] curBase = mcd_pkg::TGT_BASE[cur.target];
  wire [6:0] memAddr = 7'(curBase + {3'h0, idx});
  wire rdChan = isGlobal(cur.target) ? 1'b0 : chanSel;
  wire wrStep = isByte && state == mcd_pkg::ST_WRITE && idx < curLen;

  wire isRead = dec.kind == mcd_pkg::K_READ || dec.kind == mcd_pkg::K_REV
    || dec.kind == mcd_pkg::K_LINE_IO || dec.kind == mcd_pkg::K_RT;
  wire doDeact = cmdTake && dec.kind == mcd_pkg::K_DEACT;
  wire doActivate = cmdTake && dec.kind == mcd_pkg::K_ACT;
  wire doSoftRst = cmdTake && dec.kind == mcd_pkg::K_SRST;
  wire doHardRst = cmdTake && dec.kind == mcd_pkg::K_HRST;

  //////////////////////////////////////////////////////////////////////////
  // Upstream reply

  wire txBusy = upReq ^ ackSync;
  wire [3:0] sendLen = cur.kind == mcd_pkg::K_READ ? curLen
    : cur.kind == mcd_pkg::K_IDENT ? mcd_pkg::IDENT_LEN : 4'h1;
  wire sendStep = state == mcd_pkg::ST_SEND && !txBusy;
  wire lastIdx = idx == 4'(sendLen - 4'h1);
  wire lastStep = sendStep && lastIdx;
  wire [7:0] identByte = idx == 4'h0
    ? (mcd_pkg::IDENT_HEAD | {3'h0, chanSel, 4'h0})
    : mcd_pkg::IDENT_TYPE;
  wire [7:0] readByte = cur.kind == mcd_pkg::K_READ ? mem[rdChan][memAddr]
    : cur.kind == mcd_pkg::K_REV ? REVISION
    : cur.kind == mcd_pkg::K_LINE_IO ? ioSync
    : cur.kind == mcd_pkg::K_RT ? rtSync
    : identByte;

  always_comb begin
    next_state = state;
    unique case (state)
      mcd_pkg::ST_ADDR: begin
        if (isByte) begin
          next_state = addrOk ? mcd_pkg::ST_CMD : mcd_pkg::ST_DRAIN;
        end
      end
      mcd_pkg::ST_CMD: begin
        if (isEom) begin
          next_state = mcd_pkg::ST_ADDR;
        end else if (identTake) begin
          next_state = mcd_pkg::ST_SEND;
        end else if (cmdTake && dec.kind == mcd_pkg::K_WRITE) begin
          next_state = mcd_pkg::ST_WRITE;
        end else if (cmdTake && isRead) begin
          next_state = mcd_pkg::ST_SEND;
        end else if (isByte) begin
          next_state = mcd_pkg::ST_DRAIN;
        end
      end
      mcd_pkg::ST_WRITE: begin
        if (isEom) begin
          next_state = mcd_pkg::ST_ADDR;
        end
      end
      mcd_pkg::ST_SEND: begin
        if (lastStep) begin
          next_state = mcd_pkg::ST_DRAIN;
        end
      end
      mcd_pkg::ST_DRAIN: begin
        if (isEom) begin
          next_state = mcd_pkg::ST_ADDR;
        end
      end
      default: begin
        next_state = mcd_pkg::ST_ADDR;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= mcd_pkg::ST_ADDR;
      addrByte <= 8'h00;
    end else begin
      state <= next_state;
      if (isByte && state == mcd_pkg::ST_ADDR) begin
        addrByte <= dnHold.data;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cur <= '0;
      idx <= 4'h0;
    end else if (identTake) begin
      cur.kind <= mcd_pkg::K_IDENT;
      idx <= 4'h0;
    end else if (cmdTake) begin
      cur <= dec;
      idx <= 4'h0;
    end else if (wrStep || sendStep) begin
      idx <= 4'(idx + 4'h1);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      upReq <= 1'b0;
      upHold <= '0;
    end else if (sendStep) begin
      upHold.data <= readByte;
      upHold.last <= lastIdx;
      upReq <= ~upReq;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reset commands

  always_ff @(posedge clock) begin
    if (srst) begin
      softRst <= 2'b00;
      hardRst <= 1'b0;
    end else begin
      softRst <= doSoftRst ? tgtMask : 2'b00;
      hardRst <= doHardRst;
    end
  end

  assign chanResetPulse = softRst;
  assign chipResetPulse = hardRst;
  assign chipCfg = mem[0][mcd_pkg::TGT_BASE[mcd_pkg::TGT_CHIP]];

  //////////////////////////////////////////////////////////////////////////
  // Configuration and coefficient storage

  genvar ch;
  genvar b;
  generate
    for (ch = 0; ch < 2; ch++) begin : gChan
      for (b = 0; b < mcd_pkg::MEM_BYTES; b++) begin : gByte
        localparam bit KEEP = b == mcd_pkg::TGT_BASE[mcd_pkg::TGT_GKI]
          || b == mcd_pkg::TGT_BASE[mcd_pkg::TGT_CHIP];
        wire hit = wrStep && wrMask[ch] && memAddr == 7'(b);
        always_ff @(posedge clock) begin
          if (srst || hardRst) begin
            mem[ch][b] <= mcd_pkg::CFG_RESET;
          end else if (softRst[ch] && !KEEP) begin
            mem[ch][b] <= mcd_pkg::CFG_RESET;
          end else if (hit) begin
            mem[ch][b] <= dnHold.data;
          end
        end
      end

      // Channel activation and voice gating
      logic [1:0] frames;
      always_ff @(posedge clock) begin
        if (srst || hardRst || softRst[ch]) begin
          channelActive[ch] <= 1'b0;
          frames <= 2'h0;
          voiceValid[ch] <= 1'b0;
        end else if (doDeact && tgtMask[ch]) begin
          channelActive[ch] <= 1'b0;
          frames <= 2'h0;
          voiceValid[ch] <= 1'b0;
        end else if (doActivate && tgtMask[ch]) begin
          channelActive[ch] <= 1'b1;
          frames <= 2'h0;
          voiceValid[ch] <= 1'b0;
        end else begin
          if (fscEvent && channelActive[ch] && frames != mcd_pkg::VOICE_FRAMES) begin
            frames <= 2'(frames + 2'h1);
          end
          voiceValid[ch] <= channelActive[ch]
            && frames == mcd_pkg::VOICE_FRAMES;
        end
      end
    end
  endgenerate

endmodule

// *** monitor_command_decoder_monitor.sv ***
`timescale 1ns/1ns
module mcd_monitor (
  input wire logic clock,
  input wire logic srst,
  input wire logic linkClock,
  input wire logic dnStrobe,
  input wire logic [7:0] dnData,
  input wire logic dnEnd,
  input wire logic frameSync,
  input wire logic upTake,
  input wire logic [7:0] lineIoIn,
  input wire logic [7:0] realTimeIn,
  input wire logic [7:0] upByte,
  input wire logic upValid,
  input wire logic upLast,
  input wire logic [1:0] channelActive,
  input wire logic [1:0] voiceValid,
  input wire logic [1:0] chanResetPulse,
  input wire logic chipResetPulse,
  input wire logic [7:0] chipCfg
);
  sequence activated;
    $rose(channelActive[0]);
  endsequence
  sequence voiceQuiet;
    !voiceValid[0] [*8];
  endsequence
  chk_valid_holds: assert property (@(posedge linkClock) disable iff (srst)
    upValid && !upTake |=> upValid && $stable(upByte) && $stable(upLast))
    else $error("reply byte changed before it was taken");
  chk_take_drops: assert property (@(posedge linkClock) disable iff (srst)
    upValid && upTake |=> !upValid [*2])
    else $error("reply valid stayed up after take");
  chk_chip_pulse: assert property (@(posedge clock) disable iff (srst)
    chipResetPulse |=> !chipResetPulse)
    else $error("chip reset pulse longer than one cycle");
  chk_chip_clears: assert property (@(posedge clock) disable iff (srst)
    chipResetPulse |-> ##[0:4] (channelActive == 2'h0 && chipCfg == 8'h00))
    else $error("chip reset left state behind");
  chk_chan_pulse: assert property (@(posedge clock) disable iff (srst)
    chanResetPulse[0] |=> !chanResetPulse[0])
    else $error("channel reset pulse longer than one cycle");
  chk_chan_clears: assert property (@(posedge clock) disable iff (srst)
    chanResetPulse[0] |-> ##[0:4] !channelActive[0])
    else $error("channel reset left channel active");
  chk_idle_no_voice: assert property (@(posedge clock) disable iff (srst)
    !channelActive[0] && !$past(channelActive[0]) |-> !voiceValid[0])
    else $error("voice valid on idle channel");
  chk_voice_waits: assert property (@(posedge clock) disable iff (srst)
    activated |=> voiceQuiet)
    else $error("voice valid too soon after activation");
endmodule
bind monitor_command_decoder mcd_monitor u_mcd_monitor (.clock(clock), .srst(srst),
  .linkClock(linkClock), .dnStrobe(dnStrobe), .dnData(dnData), .dnEnd(dnEnd),
  .frameSync(frameSync), .upTake(upTake), .lineIoIn(lineIoIn), .realTimeIn(realTimeIn),
  .upByte(upByte), .upValid(upValid), .upLast(upLast), .channelActive(channelActive),
  .voiceValid(voiceValid), .chanResetPulse(chanResetPulse),
  .chipResetPulse(chipResetPulse), .chipCfg(chipCfg));

// *** link_ctrl_model.sv ***
`timescale 1ns/1ns
module link_ctrl_model (
  input wire logic linkClock,
  input wire logic [7:0] upByte,
  input wire logic upValid,
  input wire logic upLast,
  output logic dnStrobe,
  output logic [7:0] dnData,
  output logic dnEnd,
  output logic frameSync,
  output logic upTake
);
  int takeDelay = 0;
  initial begin
    {dnStrobe, dnEnd, frameSync, upTake} = 4'h0;
    dnData = 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  // Kind 0 byte, 1 end of message, 2 frame sync; data inverted once released
  task automatic pulse(input logic [1:0] kind, input logic [7:0] b);
    @(negedge linkClock);
    dnStrobe = kind == 2'h0;
    dnEnd = kind == 2'h1;
    frameSync = kind == 2'h2;
    dnData = b;
    @(negedge linkClock);
    {dnStrobe, dnEnd, frameSync} = 3'h0;
    dnData = ~b;
    @(negedge linkClock);
  endtask
  // Collects reply bytes until the last one, taking each after takeDelay
  task automatic getReply(output logic [7:0] q[$]);
    int w;
    logic last;
    last = 1'b0;
    w = 0;
    while (!last && w < 200) begin
      @(negedge linkClock);
      w++;
      if (upValid === 1'b1) begin
        repeat (takeDelay) @(negedge linkClock);
        q.push_back(upByte);
        last = upLast;
        upTake = 1'b1;
        @(negedge linkClock);
        upTake = 1'b0;
      end
    end
    // A missing last marker shows up as one extra byte
    if (!last) q.push_back(8'h00);
  endtask
endmodule

// *** monitor_command_decoder_bench.sv ***
`timescale 1ns/1ns
module monitor_command_decoder_bench;
  // Arbitrary value
  localparam logic [7:0] REV_CODE = 8'h3c;
  localparam logic [7:0] CODES [17] = '{8'h70, 8'h46, 8'h60, 8'h54, 8'h4a, 8'hc8,
    8'he8, 8'h6c, 8'h50, 8'h80, 8'h82, 8'h98, 8'h86, 8'h88, 8'h8a, 8'h96, 8'h9a};
  logic clock = 1'b0;
  logic linkClock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] lineIoIn = 8'h5a;
  logic [7:0] realTimeIn = 8'hc3;
  logic dnStrobe, dnEnd, frameSync, upTake, upValid, upLast, chipResetPulse;
  logic [7:0] dnData, upByte, chipCfg;
  logic [1:0] channelActive, voiceValid, chanResetPulse;
  logic [2:0] seenPulse = 3'h0;
  logic [7:0] got[$];
  logic [7:0] expQ[$];
  int failCount = 0;
  int samplesChecked = 0;
  always #2 clock = ~clock;
  // Link clock is offset so its edges never meet core clock edges
  initial begin
    #3;
    forever #32 linkClock = ~linkClock;
  end
  always @(posedge clock) begin
    if (srst) seenPulse <= 3'h0;
    else seenPulse <= seenPulse | {chipResetPulse, chanResetPulse};
  end
  monitor_command_decoder #(.REVISION(REV_CODE)) u_monitor_command_decoder (
    .clock(clock), .srst(srst), .linkClock(linkClock), .dnStrobe(dnStrobe),
    .dnData(dnData), .dnEnd(dnEnd), .frameSync(frameSync), .upTake(upTake),
    .lineIoIn(lineIoIn), .realTimeIn(realTimeIn), .upByte(upByte), .upValid(upValid),
    .upLast(upLast), .channelActive(channelActive), .voiceValid(voiceValid),
    .chanResetPulse(chanResetPulse), .chipResetPulse(chipResetPulse), .chipCfg(chipCfg));
  link_ctrl_model u_link (.linkClock(linkClock), .upByte(upByte), .upValid(upValid),
    .upLast(upLast), .dnStrobe(dnStrobe), .dnData(dnData), .dnEnd(dnEnd),
    .frameSync(frameSync), .upTake(upTake));
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pat(input int i, input int k);
    return 8'(8'h11 * (i + 1) + k);
  endfunction
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    samplesChecked++;
    if (g !== e) begin
      failCount++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic settle();
    repeat (40) @(negedge clock);
  endtask
  task automatic doCmd(input logic [7:0] a, input logic [7:0] c);
    u_link.pulse(2'h0, a);
    u_link.pulse(2'h0, c);
    u_link.pulse(2'h1, 8'h00);
    settle();
  endtask
  task automatic writeSet(input logic [7:0] a, input int i, input int n);
    u_link.pulse(2'h0, a);
    u_link.pulse(2'h0, CODES[i]);
    for (int k = 0; k < n; k++) u_link.pulse(2'h0, pat(i, k));
    u_link.pulse(2'h1, 8'h00);
  endtask
  task automatic readCheck(input logic [7:0] a, input logic [7:0] c);
    got.delete();
    u_link.pulse(2'h0, a);
    u_link.pulse(2'h0, c);
    u_link.getReply(got);
    u_link.pulse(2'h1, 8'h00);
    check(8'(got.size()), 8'(expQ.size()));
    foreach (expQ[k]) check(k < got.size() ? got[k] : ~expQ[k], expQ[k]);
    expQ.delete();
  endtask
  task automatic finishTest();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    // Link side needs several link periods of reset
    repeat (64) @(negedge clock);
    srst = 1'b0;
    repeat (80) @(negedge clock);
    for (int i = 0; i < 17; i++) writeSet(8'h81, i, int'(mcd_pkg::TGT_LEN[i]) + (i < 8));
    for (int i = 0; i < 17; i++) begin
      for (int k = 0; k < int'(mcd_pkg::TGT_LEN[i]); k++) expQ.push_back(pat(i, k));
      readCheck(8'h81, CODES[i] + 8'h01);
    end
    check(chipCfg, pat(1, 0));
    $display("test registers done");
    u_link.takeDelay = 5;
    expQ = '{REV_CODE};
    readCheck(8'h81, 8'h73);
    expQ = '{8'h5a};
    readCheck(8'h81, 8'h53);
    expQ = '{8'hc3};
    readCheck(8'h81, 8'h4d);
    expQ = '{8'hc3};
    readCheck(8'h81, 8'h4f);
    expQ = '{8'h80, 8'h86};
    readCheck(8'h80, 8'h00);
    expQ = '{8'h90, 8'h86};
    readCheck(8'h90, 8'h00);
    u_link.takeDelay = 0;
    // Refused addresses carry a value that would show if it landed
    for (int j = 0; j < 2; j++) begin
      u_link.pulse(2'h0, j ? 8'h88 : 8'h82);
      u_link.pulse(2'h0, 8'h70);
      u_link.pulse(2'h0, 8'hee);
      u_link.pulse(2'h1, 8'h00);
    end
    writeSet(8'h89, 13, 0);
    expQ = '{pat(0, 0)};
    readCheck(8'h81, 8'h71);
    doCmd(8'h89, 8'h70);
    writeSet(8'h89, 0, 1);
    expQ = '{pat(0, 0)};
    readCheck(8'h91, 8'h71);
    $display("test reads done");
    doCmd(8'h81, 8'h0e);
    check(8'(channelActive), 8'h01);
    u_link.pulse(2'h2, 8'h00);
    settle();
    check(8'(voiceValid), 8'h00);
    u_link.pulse(2'h2, 8'h00);
    settle();
    check(8'(voiceValid), 8'h01);
    doCmd(8'h91, 8'h0e);
    check(8'(channelActive), 8'h03);
    repeat (2) u_link.pulse(2'h2, 8'h00);
    settle();
    check(8'(voiceValid), 8'h03);
    doCmd(8'h81, 8'h02);
    check(8'(seenPulse), 8'h01);
    check(8'(channelActive), 8'h02);
    check(chipCfg, pat(1, 0));
    expQ = '{8'h00};
    readCheck(8'h81, 8'h71);
    expQ = '{pat(6, 0)};
    readCheck(8'h81, 8'he9);
    doCmd(8'h91, 8'h00);
    check(8'(channelActive), 8'h00);
    expQ = '{pat(0, 0)};
    readCheck(8'h91, 8'h71);
    doCmd(8'h81, 8'h0e);
    doCmd(8'h81, 8'h04);
    check(8'(seenPulse[2]), 8'h01);
    check(8'(channelActive), 8'h00);
    check(chipCfg, 8'h00);
    expQ = '{8'h00};
    readCheck(8'h91, 8'h71);
    $display("test channel commands done");
    finishTest();
  end
  initial begin
    #200000;
    failCount++;
    $display("watchdog expired");
    finishTest();
  end
endmodule
